// [rtl/omc_clock_gating.sv]
// Purpose: operating mode controller, top level with register port
// Assumes: halt/wake from cpu core are synchronous to core_clk_in
// Notes:   clock gates are registered enables, not glitch-free clock cells
//
// Local design decisions: the register offsets and the plain strobed port.
module omc_clock_gating (
	input  wire logic        core_clk_in,   // core clock 200 MHz
	input  wire logic        reset_n_in,    // async reset, low
	input  wire logic [3:0]  addr_in,       // register address
	input  wire logic [7:0]  wdata_in,      // write data
	input  wire logic        wr_in,         // write strobe
	input  wire logic        rd_in,         // read strobe
	input  wire logic        halt_in,       // halt instruction pulse
	input  wire logic        wake_in,       // wake event pulse
	output logic [7:0]       rdata_out,     // read data, one cycle later
	output omc_pkg::omc_gates_t gates_out,  // oscillator and clock gates
	output logic             sys_tick_out,  // system clock enable tick
	output omc_pkg::omc_mode_t  mode_out    // current mode (registered)
);
	import omc_pkg::*;

	// ************************************************************
	// registers
	// ************************************************************
	logic [7:0] system_clock_ctrl_reg;   // select and keeps
	logic [7:0] osc_ctrl;                // osc enable, watchdog enable
	omc_mode_t  mode;                    // fsm state
	omc_gates_t next_gates;              // gate decode
	logic       div_tick;                // divided fast tick
	logic [7:0] next_rdata;              // read mux
	wire  [2:0] sys_clk_select = system_clock_ctrl_reg[OMC_SEL_HI:OMC_SEL_LO];
	wire        hs_idle_keep = system_clock_ctrl_reg[OMC_HS_KEEP];
	wire        ls_idle_keep = system_clock_ctrl_reg[OMC_LS_KEEP];
	wire        hs_en = osc_ctrl[OMC_HS_EN];
	wire        wdt_en = osc_ctrl[OMC_WDT_EN];
	wire        wr_scc = wr_in && (addr_in == OMC_ADDR_SCC);
	wire        wr_osc = wr_in && (addr_in == OMC_ADDR_OSC);

	// only bits 7-5, 1, 0 are kept
	localparam logic [7:0] SCC_MASK = 8'he3;
	localparam logic [7:0] OSC_MASK = 8'h03;

	// register writes; unused bits read zero
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			system_clock_ctrl_reg <= OMC_SCC_RESET;
			osc_ctrl              <= OMC_OSC_RESET;
		end else begin
			if (wr_scc) system_clock_ctrl_reg <= wdata_in & SCC_MASK;
			if (wr_osc) osc_ctrl <= wdata_in & OSC_MASK;
		end
	end

	// ************************************************************
	// mode machine and divider
	// ************************************************************
	omc_mode_fsm u_fsm (
		.core_clk_in (core_clk_in),
		.reset_n_in  (reset_n_in),
		.halt_in     (halt_in),
		.wake_in     (wake_in),
		.hs_keep_in  (hs_idle_keep),
		.ls_keep_in  (ls_idle_keep),
		.sel_in      (sys_clk_select),
		.mode_out    (mode)
	);

	omc_divider u_div (
		.core_clk_in (core_clk_in),
		.reset_n_in  (reset_n_in),
		.run_in      (next_gates.hs_osc_en),
		.sel_in      (sys_clk_select),
		.tick_out    (div_tick)
	);

	// ************************************************************
	// gate decode per mode
	// ************************************************************
	always_comb begin
		next_gates = '{cpu_clk_en: 1'b0, hs_osc_en: 1'b0, sub_clk_en: 1'b0, low_speed_rc_osc_en: 1'b0};
		case (mode)
			OMC_FAST: next_gates = '{1'b1, 1'b1, 1'b1, 1'b1};
			OMC_SLOW: next_gates = '{1'b1, hs_en, 1'b1, 1'b1};
			OMC_SLEEP: next_gates = '{1'b0, 1'b0, 1'b0, wdt_en};
			OMC_IDLE_LS: next_gates = '{1'b0, 1'b0, 1'b1, 1'b1};
			OMC_IDLE_BOTH: next_gates = '{1'b0, 1'b1, 1'b1, 1'b1};
			OMC_IDLE_HS: next_gates = '{1'b0, 1'b1, 1'b0, 1'b0};
			default: next_gates = '{1'b1, 1'b1, 1'b1, 1'b1};
		endcase
	end

	// read mux; unmapped reads zero
	always_comb begin
		case (addr_in)
			OMC_ADDR_SCC:    next_rdata = system_clock_ctrl_reg;
			OMC_ADDR_OSC:    next_rdata = osc_ctrl;
			OMC_ADDR_STATUS: next_rdata = {1'b0, mode, next_gates};
			default:         next_rdata = 8'h00;
		endcase
	end

	// ************************************************************
	// registered outputs
	// ************************************************************
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_out    <= 8'h00;
			gates_out    <= '{1'b1, 1'b1, 1'b1, 1'b1};
			sys_tick_out <= 1'b0;
			mode_out     <= OMC_FAST;
		end else begin
			rdata_out    <= rd_in ? next_rdata : 8'h00;
			gates_out    <= next_gates;
			// slow tick is sub clock enable (whole core clock)
			sys_tick_out <= next_gates.cpu_clk_en
				& ((mode == OMC_SLOW) ? 1'b1 : div_tick);
			mode_out     <= mode;
		end
	end
endmodule // omc_clock_gating

// [rtl/omc_pkg.sv]
// Purpose: constants and types for the operating mode clock gating block
// Assumes: one 200 MHz core clock, 8-bit register port
// Notes:   register offsets are local choices
package omc_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [3:0] OMC_ADDR_SCC    = 4'h0; // system clock control
	localparam logic [3:0] OMC_ADDR_OSC    = 4'h1; // oscillator / watchdog control
	localparam logic [3:0] OMC_ADDR_STATUS = 4'h2; // mode and gate status
	localparam logic [7:0] OMC_SCC_RESET   = 8'h00; // select 000, keeps off
	localparam logic [7:0] OMC_OSC_RESET   = 8'h01; // fast osc enable set
	localparam int OMC_SEL_HI  = 7;  // select field top bit
	localparam int OMC_SEL_LO  = 5;  // select field low bit
	localparam int OMC_HS_KEEP = 1;  // high-speed idle keep
	localparam int OMC_LS_KEEP = 0;  // low-speed idle keep
	localparam int OMC_HS_EN   = 0;  // fast oscillator enable (osc reg)
	localparam int OMC_WDT_EN  = 1;  // watchdog enable (osc reg)
	localparam logic [2:0] OMC_SEL_SUB = 3'h7; // select code for sub clock
	localparam logic [5:0] OMC_DIV_ONE = 6'h00; // divider terminal value

	// ************************************************************
	// operating modes and gate bundle
	// ************************************************************
	typedef enum logic [2:0] {
		OMC_FAST, OMC_SLOW, OMC_SLEEP, OMC_IDLE_LS, OMC_IDLE_BOTH, OMC_IDLE_HS
	} omc_mode_t;

	typedef struct packed {
		logic cpu_clk_en;  // cpu clock gate
		logic hs_osc_en;   // fast oscillator run
		logic sub_clk_en;  // sub clock to peripherals
		logic low_speed_rc_osc_en;     // slow oscillator run
	} omc_gates_t;
endpackage

// [rtl/omc_divider.sv]
// Purpose: fast clock prescaler producing a tick each 2^sel cycles
// Assumes: sel below 7, power-of-two ratios 1..64
// Notes:   output is a registered enable tick, not a new clock
module omc_divider (
	input  wire logic       core_clk_in,   // core clock
	input  wire logic       reset_n_in,    // async reset, low
	input  wire logic       run_in,        // fast oscillator running
	input  wire logic [2:0] sel_in,        // divide select
	output logic            tick_out       // divided tick
);
	import omc_pkg::*;
	logic [5:0] count;       // free count
	logic [5:0] mask;        // low bits to wrap on
	wire        wrap;        // ratio reached

	// ratio 2^sel as a mask of low ones
	assign mask = 6'(({6'h00, 1'b1} << sel_in) - 7'h01);
	assign wrap = (count & mask) == OMC_DIV_ONE;

	// ************************************************************
	// counter and tick
	// ************************************************************
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count    <= 6'h00;
			tick_out <= 1'b0;
		end else begin
			count    <= run_in ? 6'(count + 6'h01) : 6'h00;
			tick_out <= run_in & wrap;
		end
	end
endmodule // omc_divider

// [rtl/omc_mode_fsm.sv]
// Purpose: mode state machine for run and halt modes
// Assumes: halt and wake are single-cycle pulses on core clock
// Notes:   keep bits sampled only on halt
module omc_mode_fsm (
	input  wire logic             core_clk_in,  // core clock
	input  wire logic             reset_n_in,   // async reset, low
	input  wire logic             halt_in,      // halt executed
	input  wire logic             wake_in,      // wake event
	input  wire logic             hs_keep_in,   // high-speed idle keep
	input  wire logic             ls_keep_in,   // low-speed idle keep
	input  wire logic [2:0]       sel_in,       // clock select
	output omc_pkg::omc_mode_t    mode_out      // current mode
);
	import omc_pkg::*;
	omc_mode_t next_mode;    // next state
	omc_mode_t run_mode;     // running mode from select
	omc_mode_t halt_mode;    // halted mode from keep bits

	assign run_mode = (sel_in == OMC_SEL_SUB) ? OMC_SLOW : OMC_FAST;
	// keeps only used here, at halt
	assign halt_mode = !hs_keep_in ? (ls_keep_in ? OMC_IDLE_LS : OMC_SLEEP)
		: (ls_keep_in ? OMC_IDLE_BOTH : OMC_IDLE_HS);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_mode = mode_out;
		case (mode_out)
			OMC_FAST, OMC_SLOW: begin
				if (halt_in) next_mode = halt_mode;
				else next_mode = run_mode;
			end
			OMC_SLEEP, OMC_IDLE_LS, OMC_IDLE_BOTH, OMC_IDLE_HS: begin
				// wake returns to selected running mode
				if (wake_in) next_mode = run_mode;
			end
			default: next_mode = OMC_FAST;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) mode_out <= OMC_FAST;
		else mode_out <= next_mode;
	end
endmodule // omc_mode_fsm

// [dv/omc_clock_gating_assertions.sv]
// Purpose: port checks for the mode controller
// Assumes: one clock domain, async low reset
// Notes:   sees the top ports only, no register state
module omc_clock_gating_assertions (
	input wire logic                rd_in,        // read strobe
	input wire logic                core_clk_in,  // core clock
	input wire logic                reset_n_in,   // reset, low
	input wire logic                halt_in,      // halt pulse
	input wire logic                wake_in,      // wake pulse
	input wire logic [7:0]          rdata_out,    // read data
	input wire omc_pkg::omc_gates_t gates_out,    // gates
	input wire omc_pkg::omc_mode_t  mode_out      // mode
);
	import omc_pkg::*;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	// cpu running view of the registered mode
	wire run = (mode_out == OMC_FAST) || (mode_out == OMC_SLOW);
	// ************************************************************
	// gate pattern of each mode
	// ************************************************************
	chk_fast_all_on: assert property (mode_out == OMC_FAST |-> gates_out == 4'hf)
		else $error("fast mode gates wrong");
	chk_slow_cpu_sub: assert property (mode_out == OMC_SLOW |-> gates_out[3] && gates_out[1:0] == 2'h3)
		else $error("slow mode gates wrong");
	chk_sleep_off: assert property (mode_out == OMC_SLEEP |-> gates_out[3:1] == 3'h0)
		else $error("sleep gates wrong");
	chk_idle_ls: assert property (mode_out == OMC_IDLE_LS |-> gates_out == 4'h3)
		else $error("idle low gates wrong");
	chk_idle_both: assert property (mode_out == OMC_IDLE_BOTH |-> gates_out == 4'h7)
		else $error("idle both gates wrong");
	chk_idle_hs: assert property (mode_out == OMC_IDLE_HS |-> gates_out == 4'h4)
		else $error("idle high gates wrong");
	// ************************************************************
	// mode moves and read port
	// ************************************************************
	chk_halt_stops: assert property (halt_in && !wake_in && run |-> ##[2:3] !run)
		else $error("halt did not stop cpu");
	chk_wake_runs: assert property (wake_in && !halt_in && !run |-> ##[2:3] run)
		else $error("wake did not restart");
	chk_read_quiet: assert property (!rd_in |=> rdata_out == 8'h00)
		else $error("read data outside slot");
	cover property (mode_out == OMC_IDLE_BOTH);
	cover property (mode_out == OMC_SLEEP);
	cover property (mode_out == OMC_SLOW);
endmodule // omc_clock_gating_assertions
bind omc_clock_gating omc_clock_gating_assertions i_chk (.rd_in(rd_in), .core_clk_in(core_clk_in),
	.reset_n_in(reset_n_in), .halt_in(halt_in), .wake_in(wake_in), .rdata_out(rdata_out),
	.gates_out(gates_out), .mode_out(mode_out));

// [dv/tb_omc_clock_gating.sv]
// Purpose: directed bench for the mode controller
// Assumes: 200 MHz core clock, register port of the top
// Notes:   fixed waits follow the two-edge mode latency
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb_omc_clock_gating;
	timeunit 1ns;
	timeprecision 1ps;
	import omc_pkg::*;
	logic       core_clk_in = 1'b0;  // clock
	logic       reset_n_in  = 1'b0;  // reset, low
	logic [3:0] addr_in     = 4'h0;  // address
	logic [7:0] wdata_in    = 8'h00; // write data
	logic       wr_in       = 1'b0;  // write strobe
	logic       rd_in       = 1'b0;  // read strobe
	logic       halt_in     = 1'b0;  // halt pulse
	logic       wake_in     = 1'b0;  // wake pulse
	logic [7:0] rdata_out;           // read data
	omc_gates_t gates_out;           // gates
	logic       sys_tick_out;        // tick
	omc_mode_t  mode_out;            // mode
	int         bad_count   = 0;     // mismatches
	int         checks      = 0;     // comparisons
	omc_clock_gating i_dut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.halt_in(halt_in), .wake_in(wake_in), .rdata_out(rdata_out),
		.gates_out(gates_out), .sys_tick_out(sys_tick_out), .mode_out(mode_out));
	// free running core clock
	initial begin
		forever #2.5 core_clk_in = ~core_clk_in;
	end
	// ************************************************************
	// bus and pulse tasks
	// ************************************************************
	task automatic cyc(int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge core_clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge core_clk_in);
		wr_in <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(logic [3:0] a, logic [7:0] e);
		@(posedge core_clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge core_clk_in);
		rd_in <= 1'b0;
		#1;
		`CHK(rdata_out, e)
	endtask
	// halt when h is set, wake otherwise; mode settles two edges on
	task automatic pulse(bit h);
		@(posedge core_clk_in);
		halt_in <= h;
		wake_in <= !h;
		@(posedge core_clk_in);
		halt_in <= 1'b0;
		wake_in <= 1'b0;
		cyc(3);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_regs;
		rd(OMC_ADDR_SCC, OMC_SCC_RESET);
		rd(OMC_ADDR_OSC, OMC_OSC_RESET);
		wr(OMC_ADDR_SCC, 8'hff);
		rd(OMC_ADDR_SCC, 8'he3);
		wr(4'hf, 8'h5a);
		rd(4'hf, 8'h00);
		$display("t_regs done");
	endtask
	// tick count over 128 cycles shows the ratio 2^sel, sub clock every cycle
	task automatic t_tick;
		logic [8:0] n;
		for (int s = 0; s < 8; s++) begin
			wr(OMC_ADDR_SCC, 8'(s << 5));
			cyc(8);
			n = 9'h000;
			repeat (128) begin
				cyc(1);
				n = n + 9'(sys_tick_out);
			end
			`CHK(n, 9'(s == 7 ? 128 : 128 >> s))
			`CHK(mode_out, s == 7 ? OMC_SLOW : OMC_FAST)
		end
		wr(OMC_ADDR_OSC, 8'h00);
		cyc(4);
		`CHK(gates_out.hs_osc_en, 1'b0)
		wr(OMC_ADDR_OSC, 8'h01);
		cyc(4);
		`CHK(gates_out.hs_osc_en, 1'b1)
		$display("t_tick done");
	endtask
	// every keep code, then sleep again with the watchdog on
	task automatic t_halt;
		omc_mode_t  em [4] = '{OMC_SLEEP, OMC_IDLE_LS, OMC_IDLE_HS, OMC_IDLE_BOTH};
		logic [3:0] eg [4] = '{4'h0, 4'h3, 4'h4, 4'h7};
		logic [3:0] g;
		for (int i = 0; i < 5; i++) begin
			g = eg[i % 4] | 4'(i == 4);
			wr(OMC_ADDR_OSC, {6'h00, i == 4, 1'b1});
			wr(OMC_ADDR_SCC, 8'(i % 4));
			cyc(4);
			`CHK(mode_out, OMC_FAST)
			pulse(1'b1);
			`CHK(mode_out, em[i % 4])
			`CHK(gates_out, g)
			`CHK(sys_tick_out, 1'b0)
			rd(OMC_ADDR_STATUS, {1'b0, em[i % 4], g});
			wr(OMC_ADDR_SCC, 8'h03);
			pulse(1'b1);
			`CHK(mode_out, em[i % 4])
			pulse(1'b0);
			`CHK(mode_out, OMC_FAST)
		end
		$display("t_halt done");
	endtask
	// run length limit
	initial begin
		repeat (50000) @(posedge core_clk_in);
		bad_count++;
		stop_test();
	end
	initial begin
		repeat (16) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		t_regs();
		t_tick();
		t_halt();
		stop_test();
	end
endmodule // tb_omc_clock_gating
